// ### fabric_model.sv
/*
  Crossbar and egress stand-in: grants requests whose destination is open,
  takes finished broadcast packets, logs both. Assumes the arbiter's clock.
*/
module fabric_model (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Request side
  input wire swq_pkg::fabric_req_t i_req,
  input wire logic [swq_pkg::NDEST-1:0] i_mask,
  output logic [swq_pkg::NDEST-1:0] o_dest_ready,
  output logic o_grant,
  // Broadcast egress side
  input wire logic i_take_en,
  input wire logic i_bb_valid,
  input wire logic [swq_pkg::CH_W-1:0] i_bb_chunks,
  output logic o_take
);
  timeunit 1ns;
  timeprecision 1ps;
  import swq_pkg::*;
  logic [DEST_W-1:0] sent_q[$];
  logic [CH_W-1:0] taken_q[$];
  logic [1:0] lag_ff;
  logic grant_ff;
  wire open_w = i_req.valid && i_mask[i_req.hdr.dest];
  // Grant only what is presented now, so a late selection change is not sent blind
  assign o_dest_ready = i_mask;
  assign o_grant = grant_ff && open_w;
  // Slow grant after a lag, never on two edges in a row; prompt takes
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      grant_ff <= 1'b0;
      lag_ff <= 2'h0;
      o_take <= 1'b0;
    end else begin
      if (o_grant) sent_q.push_back(i_req.hdr.dest);
      if (o_take && i_bb_valid) taken_q.push_back(i_bb_chunks);
      lag_ff <= (open_w && !grant_ff) ? lag_ff + 2'h1 : 2'h0;
      grant_ff <= !grant_ff && open_w && lag_ff == 2'h2;
      o_take <= !o_take && i_bb_valid && i_take_en;
    end
  end
endmodule // fabric_model

// ### switch_ingress_queue_arbiter.sv
/*
  Ingress queue arbiter, head-wait timeout, multicast work queue and
  broadcast buffer admission accounting, with a Wishbone register slave.
  Assumes all inputs come from logic on I_CORE_CLK (40 MHz) and that
  requesters drop a request in the cycle after its grant.
*/
// Added by the designer: the Wishbone register port and the address map.
// What this block does
// - Strict mode two: per priority 3..0, nearest acceptable, else nearest blocked.
// - Strict mode two reorders only when the head packet is blocked.
// - With limiting, sending lower/equal priority ahead decrements the counter.
// - Sending a higher priority packet ahead leaves the counter unchanged.
// - Zero counter packet goes before lower/equal priority packets behind it.
// - Higher priority packets behind always stay eligible to pass.
// - Zero counter implies zero counters for equal/higher priority ahead.
// - Limiting off at reset, enabled by a global control bit.
// - Limit value comes from a software programmable field.
// - Timer starts when the head request goes to the fabric.
// - Timer at threshold drops the packet, interrupt if enabled.
// - Timeout also reported by port-write unless disabled.
// - Reorder clears the timer and restarts for the new head.
// - Work queue takes packets from ingress ports, never broadcast buffers.
// - Work queue admits by strict priority, round robin within a priority.
// - Work queue releases in arrival order, no watermarks.
// - Work queue forwards cut-through to the broadcast buffer.
// - Work queue is a bounded buffer of 1960 bytes.
// - Work queue refuses all while free space is below 276 bytes.
// - Broadcast buffer fed only by work queue, in order, store-and-forward.
// - Broadcast buffer holds 8 packets within 280 bytes rounded to 8.
// - Broadcast buffer stops the work queue below 8 free bytes.
module switch_ingress_queue_arbiter (
  // Clock and reset
  input wire logic I_CORE_CLK,
  input wire logic I_NRST,
  // Wishbone slave
  input wire logic I_WB_CYC,
  input wire logic I_WB_STB,
  input wire logic I_WB_WE,
  input wire logic [7:0] I_WB_ADR,
  input wire logic [31:0] I_WB_DAT,
  input wire logic [3:0] I_WB_SEL,
  output logic [31:0] O_WB_DAT,
  output logic O_WB_ACK,
  // Ingress queue fill
  input wire logic I_ENQ_VALID,
  input wire swq_pkg::pkt_hdr_t I_ENQ_HDR,
  output logic O_ENQ_READY,
  // Fabric request
  input wire logic [swq_pkg::NDEST-1:0] I_DEST_READY,
  input wire logic I_REQ_GRANT,
  output swq_pkg::fabric_req_t O_REQ,
  // Timeout reporting
  output logic O_HEAD_WAIT_IRQ,
  output logic O_PORT_WRITE,
  // Multicast work queue admission
  input wire swq_pkg::mwq_req_t [swq_pkg::NPORT-1:0] I_MWQ_REQ,
  output logic O_MWQ_ACCEPT,
  output logic [swq_pkg::NPORT-1:0] O_MWQ_GRANT,
  // Broadcast buffer egress
  output logic O_BB_PKT_VALID,
  output logic [swq_pkg::CH_W-1:0] O_BB_PKT_CHUNKS,
  input wire logic I_BB_PKT_TAKE
);
  import swq_pkg::*;

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_meta_ff;
  logic rst_n_ff;

  // Two-stage release of the async reset
  always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      rst_meta_ff <= 1'b0;
      rst_n_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_n_ff <= rst_meta_ff;
    end
  end

  // ----------------------------------------------------------------
  // Register slave
  // ----------------------------------------------------------------
  logic [31:0] ctrl_ff;
  logic [31:0] nxt_ctrl;
  logic ack_ff;
  logic [31:0] rdat_ff;
  stat_reg_t stat_w;
  flow_reg_t flow_w;

  // Decode
  wire wb_hit = I_WB_CYC & I_WB_STB & ~ack_ff;
  wire wb_wr = wb_hit & I_WB_WE & (I_WB_ADR == CTRL_OFS);
  wire [31:0] rd_mux = (I_WB_ADR == CTRL_OFS) ? ctrl_ff :
                       (I_WB_ADR == STAT_OFS) ? 32'(stat_w) :
                       (I_WB_ADR == FLOW_OFS) ? 32'(flow_w) : 32'h0000_0000;

  // Control fields
  wire arb_mode_t mode = arb_mode_t'(ctrl_ff[CTRL_MODE_BIT]);
  wire rl_en = ctrl_ff[CTRL_RLE_BIT];
  wire gen_en = ctrl_ff[CTRL_GEN_BIT];
  wire irq_en = ctrl_ff[CTRL_IRQ_BIT];
  wire port_write_disable = ctrl_ff[CTRL_PWD_BIT];
  wire [RCNT_W-1:0] rl_val = ctrl_ff[CTRL_RLV_LSB +: RCNT_W];
  wire [TMR_W-1:0] thr = ctrl_ff[CTRL_THR_LSB +: TMR_W];

  // Byte-lane write merge
  always_comb begin
    nxt_ctrl = ctrl_ff;
    for (int b = 0; b < 4; b++) begin
      if (wb_wr && I_WB_SEL[b]) begin
        nxt_ctrl[8*b +: 8] = I_WB_DAT[8*b +: 8];
      end
    end
  end

  // Control register and one-cycle ack
  always_ff @(posedge I_CORE_CLK or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      ctrl_ff <= CTRL_RST;
      ack_ff <= 1'b0;
      rdat_ff <= 32'h0000_0000;
    end else begin
      ctrl_ff <= nxt_ctrl;
      ack_ff <= wb_hit;
      rdat_ff <= wb_hit ? rd_mux : rdat_ff;
    end
  end

  assign O_WB_ACK = ack_ff;
  assign O_WB_DAT = rdat_ff;

  // ----------------------------------------------------------------
  // Ingress request queue
  // ----------------------------------------------------------------
  q_entry_t q_ff [QDEPTH];
  logic [IDX_W:0] cnt_ff;
  fabric_req_t req_ff;
  logic [TMR_W-1:0] tmr_ff;
  logic [3:0] tmo_cnt_ff;
  logic irq_ff;
  logic pw_ff;
  logic [QDEPTH-1:0] live;
  logic [QDEPTH-1:0] elig;
  logic [QDEPTH-1:0] acc;
  logic [QDEPTH-1:0] dec;
  logic [IDX_W-1:0] sel;

  // Handshakes and removal
  assign O_ENQ_READY = cnt_ff < (IDX_W+1)'(QDEPTH);
  wire push = I_ENQ_VALID & O_ENQ_READY;
  wire gnt = I_REQ_GRANT & req_ff.valid;
  wire tmo = req_ff.valid & ~I_REQ_GRANT & gen_en & (thr != '0) & (tmr_ff == thr);
  wire rm = gnt | tmo;
  wire [IDX_W:0] wr_idx = cnt_ff - (IDX_W+1)'(rm);
  wire q_entry_t ld_ent = '{hdr: I_ENQ_HDR, rcnt: rl_val};

  genvar k;
  genvar i;
  generate
    for (k = 0; k < QDEPTH; k++) begin : g_ent
      logic [QDEPTH-1:0] blk;
      q_entry_t held;
      q_entry_t nxt_q;
      assign live[k] = (IDX_W+1)'(k) < cnt_ff;
      // An earlier zero-counter packet of equal or higher priority holds this one back
      for (i = 0; i < QDEPTH; i++) begin : g_blk
        if (i < k) begin : g_ahead
          assign blk[i] = live[i] & rl_en & (q_ff[i].rcnt == '0) &
                          (q_ff[i].hdr.prio >= q_ff[k].hdr.prio);
        end else begin : g_behind
          assign blk[i] = 1'b0;
        end
      end
      assign elig[k] = live[k] & ~|blk;
      assign acc[k] = elig[k] & I_DEST_READY[q_ff[k].hdr.dest];
      // Entries ahead of a sent packet of lower/equal priority lose one step
      assign dec[k] = gnt & rl_en & (IDX_W'(k) < req_ff.idx) & (q_ff[k].rcnt != '0) &
                      (req_ff.hdr.prio <= q_ff[k].hdr.prio);
      assign held = dec[k] ? '{hdr: q_ff[k].hdr, rcnt: q_ff[k].rcnt - 1'b1} : q_ff[k];
      if (k < QDEPTH - 1) begin : g_shift
        assign nxt_q = (push && wr_idx == (IDX_W+1)'(k)) ? ld_ent :
                       (rm && IDX_W'(k) >= req_ff.idx) ? q_ff[k+1] : held;
      end else begin : g_last
        assign nxt_q = (push && wr_idx == (IDX_W+1)'(k)) ? ld_ent : held;
      end
      // Entry storage
      always_ff @(posedge I_CORE_CLK or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
          q_ff[k] <= '0;
        end else begin
          q_ff[k] <= nxt_q;
        end
      end
    end
  endgenerate

  // Packet selection, later hits override earlier ones
  always_comb begin
    sel = '0;
    if (mode == ARB_STRICT2 && !acc[0]) begin
      for (int p = 0; p < NPRIO; p++) begin
        for (int j = QDEPTH - 1; j >= 0; j--) begin
          if (elig[j] && q_ff[j].hdr.prio == PRIO_W'(p)) begin
            sel = IDX_W'(j);
          end
        end
        for (int j = QDEPTH - 1; j >= 0; j--) begin
          if (acc[j] && q_ff[j].hdr.prio == PRIO_W'(p)) begin
            sel = IDX_W'(j);
          end
        end
      end
    end
  end

  // Timer keeps running only while the same packet stays selected
  wire same_req = req_ff.valid & ~rm & live[0] & (sel == req_ff.idx);
  wire [TMR_W-1:0] nxt_tmr = same_req ? tmr_ff + 1'b1 : '0;
  wire fabric_req_t nxt_req = '{valid: live[0] & ~rm, idx: sel, hdr: q_ff[sel].hdr};

  // Queue count, request, timer and reporting
  always_ff @(posedge I_CORE_CLK or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      cnt_ff <= '0;
      req_ff <= '0;
      tmr_ff <= '0;
      tmo_cnt_ff <= '0;
      irq_ff <= 1'b0;
      pw_ff <= 1'b0;
    end else begin
      cnt_ff <= wr_idx + (IDX_W+1)'(push);
      req_ff <= nxt_req;
      tmr_ff <= nxt_tmr;
      tmo_cnt_ff <= tmo_cnt_ff + 4'(tmo);
      irq_ff <= tmo & irq_en;
      pw_ff <= tmo & ~port_write_disable;
    end
  end

  assign O_REQ = req_ff;
  assign O_HEAD_WAIT_IRQ = irq_ff;
  assign O_PORT_WRITE = pw_ff;

  // ----------------------------------------------------------------
  // Multicast work queue admission
  // ----------------------------------------------------------------
  logic [MWQ_W-1:0] mwq_used_ff;
  logic [PORT_W-1:0] rr_ff;
  logic [PRIO_W-1:0] top_p;
  logic [NPORT-1:0] cand;
  logic [PORT_W-1:0] pick;
  logic [PORT_W-1:0] probe;
  logic pick_vld;
  logic [CH_W-1:0] mlen_mem [1 << LFIFO_W];
  logic [LFIFO_W-1:0] mwr_ff;
  logic [LFIFO_W-1:0] mrd_ff;

  // Highest requesting priority among ingress ports
  always_comb begin
    top_p = '0;
    for (int n = 0; n < NPORT; n++) begin
      if (I_MWQ_REQ[n].valid && I_MWQ_REQ[n].prio > top_p) begin
        top_p = I_MWQ_REQ[n].prio;
      end
    end
  end

  generate
    for (k = 0; k < NPORT; k++) begin : g_cand
      assign cand[k] = I_MWQ_REQ[k].valid & (I_MWQ_REQ[k].prio == top_p);
    end
  endgenerate

  // Round robin among equals, port after the last winner first
  always_comb begin
    pick = '0;
    pick_vld = 1'b0;
    probe = '0;
    for (int n = NPORT; n >= 1; n--) begin
      probe = rr_ff + PORT_W'(n);
      if (cand[probe]) begin
        pick = probe;
        pick_vld = 1'b1;
      end
    end
  end

  // Only ingress ports reach this arbiter
  wire [MWQ_W-1:0] mwq_free = MWQ_W'(MWQ_CAP_CH) - mwq_used_ff;
  assign O_MWQ_ACCEPT = mwq_free >= MWQ_W'(MAX_PKT_CH);
  wire admit = O_MWQ_ACCEPT & pick_vld;
  assign O_MWQ_GRANT = NPORT'(admit) << pick;
  wire [LEN_W-1:0] len_rnd = I_MWQ_REQ[pick].len + LEN_W'(CHUNK_BYTES - 1);
  wire [CH_W-1:0] adm_ch = CH_W'(len_rnd >> CHUNK_SHIFT);

  // ----------------------------------------------------------------
  // Work queue to broadcast buffer transfer
  // ----------------------------------------------------------------
  logic [CH_W-1:0] left_ff;
  logic [CH_W-1:0] bb_used_ff;
  logic [3:0] bb_pkts_ff;
  logic [3:0] bb_done_ff;
  logic [CH_W-1:0] blen_ff [BB_MAX_PKTS];
  logic [2:0] bwr_ff;
  logic [2:0] brd_ff;

  // Chunk movement, one 8-byte chunk per cycle
  wire bb_room = bb_used_ff < CH_W'(BB_CAP_CH);
  wire mwq_pkt = mwr_ff != mrd_ff;
  wire start = (left_ff == '0) & mwq_pkt & (bb_pkts_ff < 4'(BB_MAX_PKTS));
  wire fwd = bb_room & ((left_ff != '0) | start);
  wire [CH_W-1:0] head_len = mlen_mem[mrd_ff];
  wire done = fwd & (start ? head_len == CH_W'(1) : left_ff == CH_W'(1));
  wire take = I_BB_PKT_TAKE & O_BB_PKT_VALID;
  wire [CH_W-1:0] take_len = take ? blen_ff[brd_ff] : '0;

  // Length records in arrival order
  always_ff @(posedge I_CORE_CLK) begin
    if (admit) begin
      mlen_mem[mwr_ff] <= adm_ch;
    end
  end

  // Broadcast buffer packet sizes
  always_ff @(posedge I_CORE_CLK) begin
    if (fwd && start) begin
      blen_ff[bwr_ff] <= head_len;
    end
  end

  // Occupancy and pointers
  always_ff @(posedge I_CORE_CLK or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      mwq_used_ff <= '0;
      rr_ff <= '0;
      mwr_ff <= '0;
      mrd_ff <= '0;
      left_ff <= '0;
      bb_used_ff <= '0;
      bb_pkts_ff <= '0;
      bb_done_ff <= '0;
      bwr_ff <= '0;
      brd_ff <= '0;
    end else begin
      mwq_used_ff <= mwq_used_ff + (admit ? MWQ_W'(adm_ch) : '0) - MWQ_W'(fwd);
      rr_ff <= admit ? pick : rr_ff;
      mwr_ff <= mwr_ff + LFIFO_W'(admit);
      mrd_ff <= mrd_ff + LFIFO_W'(fwd & start);
      left_ff <= !fwd ? left_ff : start ? head_len - 1'b1 : left_ff - 1'b1;
      bb_used_ff <= bb_used_ff + CH_W'(fwd) - take_len;
      bb_pkts_ff <= bb_pkts_ff + 4'(fwd & start) - 4'(take);
      bb_done_ff <= bb_done_ff + 4'(done) - 4'(take);
      bwr_ff <= bwr_ff + 3'(fwd & start);
      brd_ff <= brd_ff + 3'(take);
    end
  end

  assign O_BB_PKT_VALID = bb_done_ff != '0;
  assign O_BB_PKT_CHUNKS = blen_ff[brd_ff];

  // ----------------------------------------------------------------
  // Status views
  // ----------------------------------------------------------------
  assign stat_w = '{timer: tmr_ff, rsv: '0, req_vld: req_ff.valid, tmo_cnt: tmo_cnt_ff, qcnt: cnt_ff};
  assign flow_w = '{rsv0: '0, accept: O_MWQ_ACCEPT, rsv1: '0, bb_pkts: bb_pkts_ff, rsv2: '0,
                    bb_used: bb_used_ff, mwq_used: mwq_used_ff};

endmodule // switch_ingress_queue_arbiter

// ### swq_arb_assertions.sv
/*
  Port-level checker for the ingress queue arbiter.
  Assumes it is bound to the top module and sees only its ports.
*/
// ----------------------------------------------------------------
// Checker
// ----------------------------------------------------------------
module swq_arb_checker (
  // Clock and reset
  input wire logic I_CORE_CLK,
  input wire logic I_NRST,
  // Register bus
  input wire logic I_WB_CYC,
  input wire logic I_WB_STB,
  input wire logic O_WB_ACK,
  // Timeout reporting
  input wire logic O_HEAD_WAIT_IRQ,
  input wire logic O_PORT_WRITE,
  // Work queue admission
  input wire swq_pkg::mwq_req_t [swq_pkg::NPORT-1:0] I_MWQ_REQ,
  input wire logic O_MWQ_ACCEPT,
  input wire logic [swq_pkg::NPORT-1:0] O_MWQ_GRANT,
  // Broadcast egress
  input wire logic O_BB_PKT_VALID,
  input wire logic [swq_pkg::CH_W-1:0] O_BB_PKT_CHUNKS
);
  timeunit 1ns;
  timeprecision 1ps;
  import swq_pkg::*;
  logic [NPORT-1:0] vld;
  logic [PRIO_W-1:0] maxp;
  logic [PRIO_W-1:0] gp;
  // Highest waiting priority and priority of the granted port
  always_comb begin
    maxp = '0;
    gp = '0;
    for (int k = 0; k < NPORT; k++) begin
      vld[k] = I_MWQ_REQ[k].valid;
      if (I_MWQ_REQ[k].valid && I_MWQ_REQ[k].prio > maxp) maxp = I_MWQ_REQ[k].prio;
      if (O_MWQ_GRANT[k]) gp = I_MWQ_REQ[k].prio;
    end
  end
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_NRST);
  wb_ack_latency_a: assert property (I_WB_CYC && I_WB_STB && !O_WB_ACK |=> O_WB_ACK)
    else $error("bus ack not one cycle after request");
  wb_ack_pulse_a: assert property (O_WB_ACK |=> !O_WB_ACK) else $error("bus ack longer than one cycle");
  grant_onehot_a: assert property ($onehot0(O_MWQ_GRANT)) else $error("work queue grant not one-hot");
  grant_valid_a: assert property ((O_MWQ_GRANT & ~vld) == '0) else $error("grant to idle port");
  grant_prio_a: assert property (|O_MWQ_GRANT |-> gp == maxp) else $error("grant below top priority");
  full_refuse_a: assert property (!O_MWQ_ACCEPT |-> O_MWQ_GRANT == '0) else $error("grant while full");
  free_admit_a: assert property (O_MWQ_ACCEPT && |vld |-> |O_MWQ_GRANT) else $error("no grant with space");
  bb_size_a: assert property (O_BB_PKT_VALID |-> O_BB_PKT_CHUNKS inside {[6'h01:6'h23]})
    else $error("broadcast packet size out of range");
  irq_pulse_a: assert property ($rose(O_HEAD_WAIT_IRQ) |=> !O_HEAD_WAIT_IRQ [*2])
    else $error("timeout interrupt not a single pulse");
  pw_pulse_a: assert property (O_PORT_WRITE |=> !O_PORT_WRITE) else $error("port-write not a pulse");
  prio_cover_c: cover property (|O_MWQ_GRANT && (vld & ~O_MWQ_GRANT) != '0);
  full_cover_c: cover property (!O_MWQ_ACCEPT && |vld);
  irq_cover_c: cover property (O_HEAD_WAIT_IRQ);
endmodule // swq_arb_checker

bind switch_ingress_queue_arbiter swq_arb_checker swq_arb_checker_i (
  .I_CORE_CLK(I_CORE_CLK), .I_NRST(I_NRST), .I_WB_CYC(I_WB_CYC), .I_WB_STB(I_WB_STB),
  .O_WB_ACK(O_WB_ACK), .O_HEAD_WAIT_IRQ(O_HEAD_WAIT_IRQ), .O_PORT_WRITE(O_PORT_WRITE),
  .I_MWQ_REQ(I_MWQ_REQ), .O_MWQ_ACCEPT(O_MWQ_ACCEPT), .O_MWQ_GRANT(O_MWQ_GRANT),
  .O_BB_PKT_VALID(O_BB_PKT_VALID), .O_BB_PKT_CHUNKS(O_BB_PKT_CHUNKS));

// ### swq_pkg.sv
/*
  Shared constants and carrier types for the ingress queue arbiter.
  Assumes a single fabric clock domain and 8-byte data chunks.
*/
package swq_pkg;
  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int QDEPTH = 8;
  localparam int IDX_W = 3;
  localparam int PRIO_W = 2;
  localparam int NPRIO = 4;
  localparam int DEST_W = 3;
  localparam int NDEST = 8;
  localparam int NPORT = 4;
  localparam int PORT_W = 2;
  localparam int LEN_W = 9;
  localparam int RCNT_W = 4;
  localparam int TMR_W = 16;
  localparam int CH_W = 6;
  localparam int MWQ_W = 8;
  localparam int LFIFO_W = 8;
  localparam int CHUNK_BYTES = 8;
  localparam int CHUNK_SHIFT = 3;
  localparam int MAX_PKT_BYTES = 276;
  localparam int MWQ_CAP_BYTES = 1960;
  localparam int BB_CAP_BYTES = 280;
  localparam int BB_MAX_PKTS = 8;
  localparam int MAX_PKT_CH = (MAX_PKT_BYTES + CHUNK_BYTES - 1) / CHUNK_BYTES;
  localparam int MWQ_CAP_CH = MWQ_CAP_BYTES / CHUNK_BYTES;
  localparam int BB_CAP_CH = BB_CAP_BYTES / CHUNK_BYTES;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam logic [7:0] FLOW_OFS = 8'h08;
  localparam int CTRL_MODE_BIT = 0;
  localparam int CTRL_RLE_BIT = 1;
  localparam int CTRL_GEN_BIT = 2;
  localparam int CTRL_IRQ_BIT = 3;
  localparam int CTRL_PWD_BIT = 4;
  localparam int CTRL_RLV_LSB = 8;
  localparam int CTRL_THR_LSB = 16;
  localparam logic [31:0] CTRL_RST = 32'hffff_0000;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [0:0] {ARB_ARRIVAL = 1'b0, ARB_STRICT2 = 1'b1} arb_mode_t;
  typedef struct packed {
    logic [PRIO_W-1:0] prio;
    logic [DEST_W-1:0] dest;
  } pkt_hdr_t;
  typedef struct packed {
    pkt_hdr_t hdr;
    logic [RCNT_W-1:0] rcnt;
  } q_entry_t;
  typedef struct packed {
    logic valid;
    logic [PRIO_W-1:0] prio;
    logic [LEN_W-1:0] len;
  } mwq_req_t;
  typedef struct packed {
    logic valid;
    logic [IDX_W-1:0] idx;
    pkt_hdr_t hdr;
  } fabric_req_t;
  typedef struct packed {
    logic [TMR_W-1:0] timer;
    logic [6:0] rsv;
    logic req_vld;
    logic [3:0] tmo_cnt;
    logic [3:0] qcnt;
  } stat_reg_t;
  typedef struct packed {
    logic [6:0] rsv0;
    logic accept;
    logic [3:0] rsv1;
    logic [3:0] bb_pkts;
    logic [1:0] rsv2;
    logic [CH_W-1:0] bb_used;
    logic [MWQ_W-1:0] mwq_used;
  } flow_reg_t;
endpackage

// ### testbench.sv
/*
  Self-checking bench for the ingress queue arbiter.
  Assumes the fabric model answers requests and takes broadcast packets.
*/
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import swq_pkg::*;
  logic clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, enq_v = 0, take_en = 0;
  logic [7:0] adr = '0, mask = '0, ptab = 8'h3d;
  logic [31:0] wdat = '0, rdat;
  logic [3:0] sel = '0, mv;
  pkt_hdr_t hdr = '0;
  mwq_req_t [NPORT-1:0] mreq = '0;
  wire logic [31:0] wb_dat;
  wire logic ack, enq_rdy, grant, irq, pw, acc, bb_v, take;
  wire logic [7:0] dest_rdy;
  wire logic [3:0] mgnt;
  wire logic [5:0] bb_ch;
  fabric_req_t req;
  int err_count = 0, compares = 0, irq_n = 0, pw_n = 0;
  logic [1:0] gq[$];
  // ----------------------------------------------------------------
  // Clock, instances and monitors
  // ----------------------------------------------------------------
  always #12.5 clk = ~clk;
  switch_ingress_queue_arbiter switch_ingress_queue_arbiter_i (.I_CORE_CLK(clk), .I_NRST(rst_n),
    .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_DAT(wdat), .I_WB_SEL(sel),
    .O_WB_DAT(wb_dat), .O_WB_ACK(ack), .I_ENQ_VALID(enq_v), .I_ENQ_HDR(hdr), .O_ENQ_READY(enq_rdy),
    .I_DEST_READY(dest_rdy), .I_REQ_GRANT(grant), .O_REQ(req), .O_HEAD_WAIT_IRQ(irq), .O_PORT_WRITE(pw),
    .I_MWQ_REQ(mreq), .O_MWQ_ACCEPT(acc), .O_MWQ_GRANT(mgnt), .O_BB_PKT_VALID(bb_v),
    .O_BB_PKT_CHUNKS(bb_ch), .I_BB_PKT_TAKE(take));
  fabric_model fabric_model_i (.i_clk(clk), .i_rst_n(rst_n), .i_req(req), .i_mask(mask),
    .o_dest_ready(dest_rdy), .o_grant(grant), .i_take_en(take_en), .i_bb_valid(bb_v),
    .i_bb_chunks(bb_ch), .o_take(take));
  // Pending work queue requests
  always_comb for (int k = 0; k < NPORT; k++) mv[k] = mreq[k].valid;
  // Count report pulses and log granted priorities
  always @(posedge clk) begin
    if (irq === 1'b1) irq_n++;
    if (pw === 1'b1) pw_n++;
    for (int k = 0; k < NPORT; k++) if (mgnt[k] === 1'b1) gq.push_back(mreq[k].prio);
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1; stb <= 1; we <= w; adr <= a; wdat <= d; sel <= 4'hf;
    @(posedge clk);
    while (ack !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    if (n == 20) chk("bus ack", 32'h1, 32'h0);
    rdat = wb_dat;
    cyc <= 0; stb <= 0; we <= 0;
  endtask
  task rd_chk(input logic [7:0] a, input logic [31:0] exp, input string nm);
    wb(1'b0, a, 32'h0);
    chk(nm, exp, rdat);
  endtask
  task push(input logic [1:0] p, input logic [2:0] d);
    chk("enq ready", 32'h1, enq_rdy);
    @(posedge clk);
    enq_v <= 1; hdr <= '{prio: p, dest: d};
    @(posedge clk);
    enq_v <= 0;
  endtask
  task waitq(input bit bb, input int n, input int lim);
    int k;
    k = 0;
    while ((bb ? fabric_model_i.taken_q.size() : fabric_model_i.sent_q.size()) < n && k < lim) begin
      @(posedge clk);
      k++;
    end
  endtask
  task chk_order(input logic [11:0] e);
    waitq(0, 4, 300);
    for (int i = 0; i < 4; i++) chk("grant order", e[11-3*i -: 3], fabric_model_i.sent_q[i]);
    fabric_model_i.sent_q.delete();
  endtask
  task mwq_run(input int lim);
    int k;
    k = 0;
    do begin
      @(posedge clk);
      for (int j = 0; j < NPORT; j++) if (mgnt[j] === 1'b1) mreq[j].valid <= 0;
      k++;
    end while (|mv && k < lim);
  endtask
  task tally_and_finish;
    $display("errors %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    #(25 * 20000);
    err_count++;
    tally_and_finish;
  end
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1;
    repeat (3) @(posedge clk);
    rd_chk(CTRL_OFS, CTRL_RST, "ctrl reset");
    wb(1'b1, STAT_OFS, 32'hffff_ffff);
    rd_chk(STAT_OFS, 32'h0, "stat read-only");
    rd_chk(FLOW_OFS, 32'h0100_0000, "flow reset");
    rd_chk(8'h0c, 32'h0, "unmapped");
    // Strict two: blocked top priority holds back an open lower one
    wb(1'b1, CTRL_OFS, 32'hffff_0001);
    push(2'h0, 3'h0); push(2'h2, 3'h1); push(2'h3, 3'h2); push(2'h3, 3'h3);
    mask <= 8'h0a;
    waitq(0, 1, 300);
    repeat (20) @(posedge clk);
    chk("strict hold", 32'h1, fabric_model_i.sent_q.size());
    mask <= 8'hff;
    chk_order(12'h60a);
    // Reorder limit of one: head reaches zero, then only higher priority passes
    mask <= 8'h00;
    wb(1'b1, CTRL_OFS, 32'hffff_0103);
    push(2'h1, 3'h0); push(2'h1, 3'h1); push(2'h1, 3'h2);
    mask <= 8'h02;
    waitq(0, 1, 300);
    mask <= 8'h0e;
    push(2'h3, 3'h3);
    waitq(0, 2, 300);
    repeat (20) @(posedge clk);
    chk("limit hold", 32'h2, fabric_model_i.sent_q.size());
    mask <= 8'h11;
    push(2'h1, 3'h4);
    waitq(0, 4, 300);
    chk_order(12'h2c4);
    mask <= 8'hff;
    waitq(0, 1, 300);
    chk("limit tail", 32'h2, fabric_model_i.sent_q[0]);
    fabric_model_i.sent_q.delete();
    // Head wait timeout, with and without port-write
    mask <= 8'h00;
    wb(1'b1, CTRL_OFS, 32'h0005_000c);
    push(2'h0, 3'h0);
    repeat (3) @(posedge clk);
    chk("irq early", 32'h0, irq_n);
    repeat (12) @(posedge clk);
    chk("irq count", 32'h1, irq_n);
    chk("pw count", 32'h1, pw_n);
    wb(1'b0, STAT_OFS, 32'h0);
    chk("stat timeout", 32'h010, rdat[8:0]);
    wb(1'b1, CTRL_OFS, 32'h0005_001c);
    push(2'h0, 3'h0);
    repeat (15) @(posedge clk);
    chk("irq pw off", 32'h2, irq_n);
    chk("pw disabled", 32'h1, pw_n);
    wb(1'b1, CTRL_OFS, 32'h0005_0008);
    push(2'h0, 3'h0);
    repeat (15) @(posedge clk);
    chk("gen off", 32'h2, irq_n);
    mask <= 8'hff;
    waitq(0, 1, 300);
    chk("gen off kept", 32'h1, fabric_model_i.sent_q.size());
    // Work queue admission by priority
    take_en <= 1;
    @(posedge clk);
    for (int k = 0; k < NPORT; k++) mreq[k] <= '{valid: 1'b1, prio: ptab[2*k +: 2], len: 9'd8};
    mwq_run(20);
    chk("mwq prio", 32'hf4, {gq[0], gq[1], gq[2], gq[3]});
    waitq(1, 4, 300);
    fabric_model_i.taken_q.delete();
    // Fill with egress stalled, then refuse
    take_en <= 0;
    for (int i = 0; i < 8; i++) begin
      mreq[0] <= '{valid: 1'b1, prio: 2'h0, len: 9'd276};
      mwq_run(200);
      chk("mwq admit", 32'h0, mreq[0].valid);
    end
    repeat (100) @(posedge clk);
    rd_chk(FLOW_OFS, 32'h0001_23f5, "flow full");
    mreq[0] <= '{valid: 1'b1, prio: 2'h0, len: 9'd276};
    mwq_run(50);
    chk("mwq refuse", 32'h1, mreq[0].valid);
    mreq[0].valid <= 0;
    // Drain in order, whole packets
    take_en <= 1;
    waitq(1, 8, 1500);
    chk("bb packets", 32'h8, fabric_model_i.taken_q.size());
    for (int i = 0; i < 8; i++) chk("bb chunks", 32'h23, fabric_model_i.taken_q[i]);
    repeat (5) @(posedge clk);
    rd_chk(FLOW_OFS, 32'h0100_0000, "flow empty");
    tally_and_finish;
  end
endmodule // testbench
